// [inc/ast_pkg.sv]
/*
 package for the asynchronous serial transceiver: register map, field positions,
 reset values and frame timing constants.
 assumes a 32-bit apb register bus, one aligned word per register.
*/
package ast_pkg;
   localparam int          DATA_W        = 8;
   localparam int          PAR_W         = 12;
   // printed offsets are not all multiples of four, so they are indexes
   localparam logic [7:0]  IDX_RXCTL     = 8'hF0;
   localparam logic [7:0]  IDX_TXCTL     = 8'hF1;
   localparam logic [7:0]  IDX_DIVIDER   = 8'hF2;
   localparam logic [7:0]  IDX_TXDATA    = 8'hF3;
   localparam logic [7:0]  IDX_RXDATA    = 8'hF4;
   localparam logic [7:0]  IDX_IRQCTL    = 8'hF5;
   localparam logic [11:0] ADDR_RXCTL    = {2'h0, IDX_RXCTL, 2'h0};
   localparam logic [11:0] ADDR_TXCTL    = {2'h0, IDX_TXCTL, 2'h0};
   localparam logic [11:0] ADDR_DIVIDER  = {2'h0, IDX_DIVIDER, 2'h0};
   localparam logic [11:0] ADDR_TXDATA   = {2'h0, IDX_TXDATA, 2'h0};
   localparam logic [11:0] ADDR_RXDATA   = {2'h0, IDX_RXDATA, 2'h0};
   localparam logic [11:0] ADDR_IRQCTL   = {2'h0, IDX_IRQCTL, 2'h0};
   // receive control fields
   localparam int          B_RX_EN       = 7;
   localparam int          B_RX_PEN      = 6;
   localparam int          B_RX_PFMT     = 5;
   localparam int          B_RX_PERR     = 4;
   localparam int          B_RX_FERR     = 3;
   localparam int          B_PRESC_HI    = 2;
   // transmit control fields
   localparam int          B_TX_EN       = 7;
   localparam int          B_TX_PEN      = 6;
   localparam int          B_TX_PFMT     = 5;
   localparam int          B_TX_BRK      = 4;
   localparam int          B_RX_BUSY     = 3;
   localparam int          B_TX_BUSY     = 2;
   // interrupt control fields
   localparam int          B_RX_IEN      = 0;
   localparam int          B_TX_IEN      = 1;
   localparam int          B_RX_REQ      = 2;
   localparam int          B_TX_REQ      = 3;
   localparam logic [7:0]  RESET_BYTE    = 8'h00;
   localparam logic [3:0]  BREAK_BITS    = 4'h0;
   localparam int          BREAK_PERIODS = 25;
   localparam logic [4:0]  BREAK_LAST    = 5'(BREAK_PERIODS - 1);
   localparam logic [3:0]  DATA_BITS     = 4'h8;
   localparam logic [8:0]  DIV_FULL      = 9'h100;
   typedef enum logic [2:0] {
      AST_IDLE   = 3'b000,
      AST_START  = 3'b001,
      AST_DATA   = 3'b010,
      AST_PARITY = 3'b011,
      AST_STOP   = 3'b100,
      AST_BREAK  = 3'b101
   } ast_state_t;
endpackage

// [src/ast_core.sv]
/*
 asynchronous serial transceiver with apb register file, prescaler, reload baud
 divider, frame transmitter with break, and frame receiver with error checks.
 assumes CLK is the high oscillator; receive pin synchronous to CLK.
*/
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module ast_core
   import ast_pkg::*;
(
   input  wire logic               CLK,
   input  wire logic               RESET,
   input  wire logic               PSEL,
   input  wire logic               PENABLE,
   input  wire logic               PWRITE,
   input  wire logic [11:0]        PADDR,
   input  wire logic [31:0]        PWDATA,
   output logic      [31:0]        PRDATA,
   output logic                    PREADY,
   output logic                    PSLVERR,
   input  wire logic               RX_PIN,
   input  wire logic               GPIO_TX_OUT,
   input  wire logic               GPIO_TX_OE,
   output logic                    TX_PIN_OUT,
   output logic                    TX_PIN_OE,
   output logic                    RX_SERIAL_MODE,
   output logic                    RX_IRQ,
   output logic                    TX_IRQ
);
   import ast_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] rx_ctl;
   logic [7:0] tx_ctl;
   logic [7:0] baud_divider_value;
   logic [7:0] tx_data_buffer;
   logic [7:0] rx_data_buffer;
   logic       rx_irq_enable;
   logic       tx_irq_enable;
   logic       rx_request_flag;
   logic       tx_request_flag;
   logic       send_break_bit;
   logic       parity_error_flag;
   logic       frame_error_flag;

   logic wr;
   logic rd;
   assign wr      = PSEL && PENABLE && PWRITE;
   assign rd      = PSEL && !PENABLE && !PWRITE;
   assign PREADY  = 1'b1;
   assign PSLVERR = 1'b0;

   logic rx_enable_bit;
   logic tx_enable_bit;
   logic rx_parity_enable;
   logic rx_parity_format;
   logic tx_parity_enable;
   logic tx_parity_format;
   logic [2:0] prescale_select;
   assign rx_enable_bit    = rx_ctl[B_RX_EN];
   assign rx_parity_enable = rx_ctl[B_RX_PEN];
   assign rx_parity_format = rx_ctl[B_RX_PFMT];
   assign prescale_select  = rx_ctl[B_PRESC_HI:0];
   assign tx_enable_bit    = tx_ctl[B_TX_EN];
   assign tx_parity_enable = tx_ctl[B_TX_PEN];
   assign tx_parity_format = tx_ctl[B_TX_PFMT];

   // events from the engines
   logic tx_done;
   logic rx_done;
   logic rx_perr;
   logic rx_ferr;
   logic [7:0] rx_shift;
   logic tx_busy_flag;
   logic rx_busy_flag;

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         rx_ctl             <= RESET_BYTE;
         tx_ctl             <= RESET_BYTE;
         baud_divider_value <= RESET_BYTE;
         tx_data_buffer     <= RESET_BYTE;
         rx_irq_enable      <= 1'b0;
         tx_irq_enable      <= 1'b0;
      end else if (wr) begin
         unique case (PADDR)
            ADDR_RXCTL:   rx_ctl <= PWDATA[7:0];
            ADDR_TXCTL:   tx_ctl <= PWDATA[7:0];
            ADDR_DIVIDER: baud_divider_value <= PWDATA[7:0];
            ADDR_TXDATA:  tx_data_buffer <= PWDATA[7:0];
            ADDR_IRQCTL: begin
               rx_irq_enable <= PWDATA[B_RX_IEN];
               tx_irq_enable <= PWDATA[B_TX_IEN];
            end
            default: ;
         endcase
      end
   end

   // sticky flags: hardware set wins over a software clear in the same cycle
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         rx_request_flag <= 1'b0;
         tx_request_flag <= 1'b0;
      end else begin
         if (rx_done)
            rx_request_flag <= 1'b1;
         else if (wr && PADDR == ADDR_IRQCTL)
            rx_request_flag <= PWDATA[B_RX_REQ];
         if (tx_done)
            tx_request_flag <= 1'b1;
         else if (wr && PADDR == ADDR_IRQCTL)
            tx_request_flag <= PWDATA[B_TX_REQ];
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         parity_error_flag <= 1'b0;
         frame_error_flag  <= 1'b0;
         rx_data_buffer    <= RESET_BYTE;
      end else if (rx_done) begin
         parity_error_flag <= rx_perr;
         frame_error_flag  <= rx_ferr;
         rx_data_buffer    <= rx_shift;
      end else if (wr && PADDR == ADDR_RXCTL) begin
         parity_error_flag <= PWDATA[B_RX_PERR];
         frame_error_flag  <= PWDATA[B_RX_FERR];
      end else if (wr && PADDR == ADDR_RXDATA) begin
         rx_data_buffer    <= PWDATA[7:0];
      end
   end

   logic tx_kick;
   logic brk_kick;
   assign tx_kick  = wr && PADDR == ADDR_TXDATA && tx_enable_bit;
   assign brk_kick = wr && PADDR == ADDR_TXCTL && PWDATA[B_TX_EN] && PWDATA[B_TX_BRK];

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET)
         send_break_bit <= 1'b0;
      else if (tx_done)
         send_break_bit <= 1'b0;
      else if (brk_kick)
         send_break_bit <= 1'b1;
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET)
         PRDATA <= 32'h0000_0000;
      else if (rd) begin
         unique case (PADDR)
            ADDR_RXCTL:   PRDATA <= {24'h0, rx_enable_bit, rx_parity_enable,
                                     rx_parity_format, parity_error_flag,
                                     frame_error_flag, prescale_select};
            ADDR_TXCTL:   PRDATA <= {24'h0, tx_enable_bit, tx_parity_enable,
                                     tx_parity_format, send_break_bit,
                                     rx_busy_flag, tx_busy_flag, 2'h0};
            ADDR_DIVIDER: PRDATA <= {24'h0, baud_divider_value};
            ADDR_TXDATA:  PRDATA <= {24'h0, tx_data_buffer};
            ADDR_RXDATA:  PRDATA <= {24'h0, rx_data_buffer};
            ADDR_IRQCTL:  PRDATA <= {28'h0, tx_request_flag, rx_request_flag,
                                     tx_irq_enable, rx_irq_enable};
            default:      PRDATA <= 32'h0000_0000;
         endcase
      end
   end

   assign RX_IRQ = rx_irq_enable && rx_request_flag;
   assign TX_IRQ = tx_irq_enable && tx_request_flag;

   ////////////////////////////////////////////////////////////////////////////////
   // baud timing: each direction restarts its own prescaler and reload divider
   // when it leaves idle, so the start bit is a full bit and rx samples mid-bit;
   // a tick of the reload counter is half a bit, so a bit is two ticks
   localparam logic [7:0] DIV_TOP = 8'(DIV_FULL - 9'h001);
   logic [6:0] pre_mask;
   logic [1:0] dir_idle;
   logic [1:0] dir_tick;
   assign pre_mask = 7'((8'h01 << prescale_select) - 8'h01);

   // index 0 serves the transmitter, index 1 the receiver
   for (genvar g = 0; g < 2; g++) begin : g_baud
      logic [6:0] pre_cnt;
      logic [7:0] div_cnt;
      logic       pre_tick;
      assign pre_tick    = (pre_cnt & pre_mask) == pre_mask;
      assign dir_tick[g] = pre_tick && div_cnt == DIV_TOP;

      always_ff @(posedge CLK or posedge RESET) begin
         if (RESET) begin
            pre_cnt <= 7'h00;
            div_cnt <= RESET_BYTE;
         end else if (dir_idle[g]) begin
            pre_cnt <= 7'h00;
            div_cnt <= baud_divider_value;
         end else begin
            pre_cnt <= pre_cnt + 7'h01;
            if (pre_tick)
               div_cnt <= (div_cnt == DIV_TOP) ? baud_divider_value : div_cnt + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // transmitter
   ast_state_t tx_state;
   logic [5:0] tx_half;
   logic [3:0] tx_bit;
   logic [7:0] tx_shift;
   logic       tx_line;
   logic       tx_par;
   logic       tx_bit_end;
   assign tx_bit_end = dir_tick[0] && tx_half[0];
   assign tx_busy_flag = tx_state != AST_IDLE;

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         tx_state <= AST_IDLE;
         tx_half  <= 6'h00;
         tx_bit   <= 4'h0;
         tx_shift <= RESET_BYTE;
         tx_line  <= 1'b1;
         tx_par   <= 1'b0;
         tx_done  <= 1'b0;
      end else begin
         tx_done <= 1'b0;
         if (dir_tick[0])
            tx_half <= tx_half + 6'h01;
         unique case (tx_state)
            AST_IDLE: begin
               tx_line <= 1'b1;
               tx_half <= 6'h00;
               if (tx_kick) begin
                  tx_state <= AST_START;
                  tx_shift <= PWDATA[7:0];
                  tx_par   <= ^PWDATA[7:0] ^ tx_parity_format;
                  tx_line  <= 1'b0;
               end else if (brk_kick) begin
                  tx_state <= AST_BREAK;
                  tx_line  <= 1'b0;
               end
            end
            AST_START: if (tx_bit_end) begin
               tx_state <= AST_DATA;
               tx_bit   <= 4'h0;
               tx_line  <= tx_shift[0];
               tx_shift <= tx_shift >> 1;
            end
            AST_DATA: if (tx_bit_end) begin
               tx_bit <= tx_bit + 4'h1;
               if (tx_bit == DATA_BITS - 4'h1) begin
                  tx_state <= tx_parity_enable ? AST_PARITY : AST_STOP;
                  tx_line  <= tx_parity_enable ? tx_par : 1'b1;
               end else begin
                  tx_line  <= tx_shift[0];
                  tx_shift <= tx_shift >> 1;
               end
            end
            AST_PARITY: if (tx_bit_end) begin
               tx_state <= AST_STOP;
               tx_line  <= 1'b1;
            end
            AST_STOP: if (tx_bit_end) begin
               tx_state <= AST_IDLE;
               tx_done  <= 1'b1;
            end
            AST_BREAK: if (dir_tick[0] && tx_half == {BREAK_LAST, 1'b1}) begin
               tx_state <= AST_IDLE;
               tx_line  <= 1'b1;
               tx_done  <= 1'b1;
            end
            default: tx_state <= AST_IDLE;
         endcase
      end
   end

   // pin goes back to its gpio drive when the transmitter is disabled
   assign TX_PIN_OUT     = tx_enable_bit ? tx_line : GPIO_TX_OUT;
   assign TX_PIN_OE      = tx_enable_bit ? 1'b1 : GPIO_TX_OE;
   assign RX_SERIAL_MODE = rx_enable_bit;

   ////////////////////////////////////////////////////////////////////////////////
   // receiver
   ast_state_t rx_state;
   logic [4:0] rx_half;
   logic [3:0] rx_bit;
   logic       rx_prev;
   logic       rx_mid;
   logic       rx_bit_end;
   assign rx_mid     = dir_tick[1] && !rx_half[0];
   assign rx_bit_end = dir_tick[1] && rx_half[0];
   assign rx_busy_flag = rx_state != AST_IDLE;
   assign dir_idle   = {rx_state == AST_IDLE, tx_state == AST_IDLE};

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         rx_state <= AST_IDLE;
         rx_half  <= 5'h00;
         rx_bit   <= 4'h0;
         rx_prev  <= 1'b1;
         rx_shift <= RESET_BYTE;
         rx_perr  <= 1'b0;
         rx_ferr  <= 1'b0;
         rx_done  <= 1'b0;
      end else begin
         rx_prev <= RX_PIN;
         rx_done <= 1'b0;
         if (dir_tick[1])
            rx_half <= rx_half + 5'h01;
         unique case (rx_state)
            AST_IDLE: begin
               rx_half <= 5'h00;
               if (rx_enable_bit && rx_prev && !RX_PIN) begin
                  rx_state <= AST_START;
                  rx_ferr  <= 1'b0;
                  rx_perr  <= 1'b0;
               end
            end
            AST_START: begin
               if (rx_mid && RX_PIN)
                  rx_ferr <= 1'b1;
               if (rx_bit_end) begin
                  rx_state <= AST_DATA;
                  rx_bit   <= 4'h0;
               end
            end
            AST_DATA: begin
               if (rx_mid)
                  rx_shift <= {RX_PIN, rx_shift[7:1]};
               if (rx_bit_end) begin
                  rx_bit <= rx_bit + 4'h1;
                  if (rx_bit == DATA_BITS - 4'h1)
                     rx_state <= rx_parity_enable ? AST_PARITY : AST_STOP;
               end
            end
            AST_PARITY: begin
               if (rx_mid)
                  rx_perr <= (^rx_shift ^ rx_parity_format) != RX_PIN;
               if (rx_bit_end)
                  rx_state <= AST_STOP;
            end
            AST_STOP: if (rx_mid) begin
               // a low stop bit is a frame error; a break lands here too
               rx_ferr  <= rx_ferr | !RX_PIN;
               rx_state <= RX_PIN ? AST_IDLE : AST_BREAK;
               rx_done  <= RX_PIN;
            end
            AST_BREAK: if (RX_PIN) begin
               // wait for the line to recover before hunting the next start
               rx_state <= AST_IDLE;
               rx_done  <= 1'b1;
            end
            default: rx_state <= AST_IDLE;
         endcase
      end
   end
endmodule

// [verification/ast_core_chk.sv]
/*
 checker for ast_core: pin hand-over, request flags, masks and tx line timing.
 assumes zero-wait apb and a bind onto ast_core.
*/
`timescale 1ns/1ps
module ast_core_chk
   import ast_pkg::*;
(
   input wire logic        CLK,
   input wire logic        RESET,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic        GPIO_TX_OUT,
   input wire logic        GPIO_TX_OE,
   input wire logic        TX_PIN_OUT,
   input wire logic        TX_PIN_OE,
   input wire logic        RX_SERIAL_MODE,
   input wire logic        RX_IRQ,
   input wire logic        TX_IRQ
);
   logic        wr, irq_wr, tx_en, rx_en, tx_ien, rx_ien;
   logic [2:0]  presc;
   logic [7:0]  div;
   logic [31:0] bit_len, low_cnt;
   assign wr      = PSEL && PENABLE && PWRITE;
   assign irq_wr  = wr && PADDR == ADDR_IRQCTL;
   assign bit_len = (32'h100 - {24'h0, div}) << (presc + 1);
   // shadow of the software settings, so timing bounds follow the baud
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         {tx_en, rx_en, tx_ien, rx_ien, presc, div} <= '0;
      end else if (wr) begin
         case (PADDR)
            ADDR_TXCTL:   tx_en <= PWDATA[B_TX_EN];
            ADDR_RXCTL:   {rx_en, presc} <= {PWDATA[B_RX_EN], PWDATA[2:0]};
            ADDR_DIVIDER: div <= PWDATA[7:0];
            ADDR_IRQCTL:  {tx_ien, rx_ien} <= {PWDATA[B_TX_IEN], PWDATA[B_RX_IEN]};
            default:      ;
         endcase
      end
   end
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) low_cnt <= '0;
      else low_cnt <= (tx_en && !TX_PIN_OUT) ? low_cnt + 1 : '0;
   end
   ////////////////////////////////////////
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   tx_gpio_a: assert property (
      !tx_en |-> {TX_PIN_OE, TX_PIN_OUT} == {GPIO_TX_OE, GPIO_TX_OUT})
      else $error("tx pin not returned to gpio");
   tx_own_a: assert property (tx_en |-> TX_PIN_OE)
      else $error("tx pin not driven while enabled");
   rx_mode_a: assert property (RX_SERIAL_MODE == rx_en)
      else $error("rx pin mode differs from enable");
   tx_mask_a: assert property (!tx_ien |-> !TX_IRQ)
      else $error("tx interrupt while masked");
   rx_mask_a: assert property (!rx_ien |-> !RX_IRQ)
      else $error("rx interrupt while masked");
   tx_req_hold_a: assert property (TX_IRQ && !irq_wr |=> TX_IRQ)
      else $error("tx request dropped without software");
   rx_req_hold_a: assert property (RX_IRQ && !irq_wr |=> RX_IRQ)
      else $error("rx request dropped without software");
   start_len_a: assert property (tx_en && $fell(TX_PIN_OUT) |-> !TX_PIN_OUT [*6])
      else $error("start bit too short");
   low_max_a: assert property (
      tx_en && TX_PIN_OUT && low_cnt != 0 |-> low_cnt <= 25 * bit_len + 2)
      else $error("tx line low too long");
   brk_min_a: assert property (
      TX_PIN_OUT && low_cnt > 10 * bit_len |-> low_cnt + bit_len / 2 + 2 >= 25 * bit_len)
      else $error("break shorter than its periods");
   cover property ($rose(TX_IRQ));
   cover property ($rose(RX_IRQ));
   cover property (TX_PIN_OUT && low_cnt > 20 * bit_len);
endmodule
bind ast_core ast_core_chk u_chk (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .GPIO_TX_OUT(GPIO_TX_OUT),
   .GPIO_TX_OE(GPIO_TX_OE), .TX_PIN_OUT(TX_PIN_OUT), .TX_PIN_OE(TX_PIN_OE),
   .RX_SERIAL_MODE(RX_SERIAL_MODE), .RX_IRQ(RX_IRQ), .TX_IRQ(TX_IRQ));

// [verification/ast_peer.sv]
/*
 remote serial device: sends frames or long lows, decodes frames it sees.
 assumes the bench sets bit_len and rx_pen before traffic.
*/
`timescale 1ns/1ps
module ast_peer (
   input  wire logic clk,
   input  wire logic line_in,
   output logic      line_out
);
   int         bit_len = 16;
   int         got_cnt = 0;
   logic       rx_pen = 1'b0;
   logic [7:0] got_data;
   logic       got_par, got_stop;
   initial line_out = 1'b1;
   task automatic send(input logic [7:0] d, input logic pen, par, stp, input int bl);
      logic [10:0] f;
      f = {stp, par, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         if (i == 9 && !pen) continue;
         line_out <= f[i];
         repeat (bl) @(posedge clk);
      end
      line_out <= 1'b1;
   endtask
   task automatic hold_low(input int n);
      line_out <= 1'b0;
      repeat (n) @(posedge clk);
      line_out <= 1'b1;
   endtask
   ////////////////////////////////////////
   // samples mid-bit from the first low seen; a held-low line is not restarted
   always @(posedge clk) begin
      if (line_in === 1'b0) begin
         repeat (bit_len / 2) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (bit_len) @(posedge clk);
            got_data[i] = line_in;
         end
         if (rx_pen) begin
            repeat (bit_len) @(posedge clk);
            got_par = line_in;
         end
         repeat (bit_len) @(posedge clk);
         got_stop = line_in;
         got_cnt++;
         while (line_in !== 1'b1) @(posedge clk);
      end
   end
endmodule

// [verification/test_async_serial_transceiver.sv]
/*
 self-checking bench for ast_core: registers, frames both ways, errors, break.
 assumes ast_core_chk is bound and ast_peer stands on the line.
*/
`timescale 1ns/1ps
module test_async_serial_transceiver;
   import ast_pkg::*;
   logic        CLK, RESET, PSEL, PENABLE, PWRITE, RX_PIN, GPIO_TX_OUT, GPIO_TX_OE, slverr;
   logic        PREADY, PSLVERR, TX_PIN_OUT, TX_PIN_OE, RX_SERIAL_MODE, RX_IRQ, TX_IRQ;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   logic        tx_line;
   int          err_total = 0, checks = 0, seed = 598, bl = 16;
   // pin is pulled up when nobody drives it
   assign tx_line = TX_PIN_OE ? TX_PIN_OUT : 1'b1;
   ast_core u_dut (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .RX_PIN(RX_PIN), .GPIO_TX_OUT(GPIO_TX_OUT), .GPIO_TX_OE(GPIO_TX_OE),
      .TX_PIN_OUT(TX_PIN_OUT), .TX_PIN_OE(TX_PIN_OE), .RX_SERIAL_MODE(RX_SERIAL_MODE),
      .RX_IRQ(RX_IRQ), .TX_IRQ(TX_IRQ));
   ast_peer u_peer (.clk(CLK), .line_in(tx_line), .line_out(RX_PIN));
   initial begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end
   ////////////////////////////////////////
   task automatic give_verdict();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do @(posedge CLK); while (PREADY !== 1'b1);
      rd = PRDATA;
      slverr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] m, x);
      apb(1'b0, a, 32'h0);
      chk(rd & m, x);
   endtask
   task automatic wait_irq(input logic tx);
      for (int n = 0; n < 20000; n++) begin
         if ((tx ? TX_IRQ : RX_IRQ) === 1'b1) break;
         @(posedge CLK);
      end
      chk(tx ? TX_IRQ : RX_IRQ, 1'b1);
   endtask
   function automatic logic par(input logic [7:0] d, input logic odd);
      return ^d ^ odd;
   endfunction
   ////////////////////////////////////////
   initial begin
      #(100 * 60000);
      err_total++;
      give_verdict();
   end
   initial begin
      logic [11:0] am [7];
      logic [7:0]  d;
      logic        pen, odd, bad, stp;
      int          n;
      am = '{12'h3D8, ADDR_RXCTL, ADDR_TXCTL, ADDR_DIVIDER, ADDR_TXDATA, ADDR_RXDATA, ADDR_IRQCTL};
      {PSEL, PENABLE, PWRITE, PADDR, PWDATA, GPIO_TX_OE} = '0;
      GPIO_TX_OUT = 1'b1;
      RESET = 1'b1;
      repeat (20) @(posedge CLK);
      RESET <= 1'b0;
      @(posedge CLK);
      wr(12'h3D8, 32'hFF);
      chk(slverr, 1'b0);
      foreach (am[i]) rdchk(am[i], 32'hFF, 32'h00);
      d = 8'($random(seed)) & 8'hFE;
      wr(ADDR_DIVIDER, {24'h0, d});
      rdchk(ADDR_DIVIDER, 32'hFF, {24'h0, d});
      wr(ADDR_DIVIDER, 32'hFC);
      wr(ADDR_RXCTL, 32'h81);
      wr(ADDR_IRQCTL, 32'h03);
      chk(RX_SERIAL_MODE, 1'b1);
      for (int i = 0; i < 6; i++) begin
         d = 8'($random(seed));
         pen = i[0];
         odd = i[1];
         u_peer.rx_pen = pen;
         wr(ADDR_TXCTL, {24'h0, 1'b1, pen, odd, 5'h0});
         n = u_peer.got_cnt;
         wr(ADDR_TXDATA, {24'h0, d});
         rdchk(ADDR_TXCTL, 32'h04, 32'h04);
         wait_irq(1'b1);
         rdchk(ADDR_TXCTL, 32'h04, 32'h00);
         repeat (bl) @(posedge CLK);
         chk(u_peer.got_cnt, n + 1);
         chk(u_peer.got_data, d);
         if (pen) chk(u_peer.got_par, par(d, odd));
         chk(u_peer.got_stop, 1'b1);
         rdchk(ADDR_IRQCTL, 32'h08, 32'h08);
         wr(ADDR_IRQCTL, 32'h03);
         chk(TX_IRQ, 1'b0);
      end
      for (int i = 0; i < 6; i++) begin
         d = 8'($random(seed));
         pen = i[0];
         odd = i[1];
         bad = (i == 3);
         stp = (i != 5);
         wr(ADDR_RXCTL, {24'h0, 1'b1, pen, odd, 5'h1});
         fork
            u_peer.send(d, pen, par(d, odd) ^ bad, stp, bl);
            begin
               repeat (3 * bl) @(posedge CLK);
               rdchk(ADDR_TXCTL, 32'h08, 32'h08);
            end
         join
         wait_irq(1'b0);
         rdchk(ADDR_RXDATA, 32'hFF, {24'h0, d});
         rdchk(ADDR_RXCTL, 32'h18, {27'h0, bad, !stp, 3'h0});
         rdchk(ADDR_TXCTL, 32'h08, 32'h00);
         wr(ADDR_IRQCTL, 32'h03);
      end
      wr(ADDR_IRQCTL, 32'h00);
      wr(ADDR_RXCTL, 32'h81);
      u_peer.send(8'hA5, 1'b0, 1'b0, 1'b1, bl);
      repeat (bl) @(posedge CLK);
      chk(RX_IRQ, 1'b0);
      rdchk(ADDR_IRQCTL, 32'h04, 32'h04);
      wr(ADDR_IRQCTL, 32'h03);
      u_peer.hold_low(25 * bl);
      wait_irq(1'b0);
      rdchk(ADDR_RXCTL, 32'h08, 32'h08);
      wr(ADDR_IRQCTL, 32'h03);
      wr(ADDR_RXCTL, 32'h81);
      u_peer.send(8'h3C, 1'b0, 1'b0, 1'b1, bl);
      wait_irq(1'b0);
      rdchk(ADDR_RXDATA, 32'hFF, 32'h3C);
      wr(ADDR_IRQCTL, 32'h03);
      u_peer.rx_pen = 1'b0;
      wr(ADDR_TXCTL, 32'h90);
      wait_irq(1'b1);
      rdchk(ADDR_TXCTL, 32'h10, 32'h00);
      wr(ADDR_IRQCTL, 32'h03);
      for (int p = 2; p < 4; p++) begin
         bl = 4 << p;
         u_peer.bit_len = bl;
         wr(ADDR_DIVIDER, 32'hFE);
         wr(ADDR_RXCTL, 32'h80 | p);
         wr(ADDR_TXDATA, 32'h00);
         for (n = 0; n < 4000 && tx_line !== 1'b0; n++) @(posedge CLK);
         for (n = 0; n < 4000 && tx_line === 1'b0; n++) @(posedge CLK);
         chk(n >= 9 * bl - bl / 2 - 1 && n <= 9 * bl + 1, 1'b1);
         wait_irq(1'b1);
         wr(ADDR_IRQCTL, 32'h03);
      end
      wr(ADDR_TXCTL, 32'h00);
      wr(ADDR_RXCTL, 32'h00);
      chk(RX_SERIAL_MODE, 1'b0);
      repeat (12) begin
         @(posedge CLK);
         chk({TX_PIN_OE, TX_PIN_OUT}, {GPIO_TX_OE, GPIO_TX_OUT});
         {GPIO_TX_OUT, GPIO_TX_OE} <= 2'($random(seed));
      end
      give_verdict();
   end
endmodule
